/* File: shared/sync_marker_pkg.sv */
// Purpose: shared constants and carriers for the reference sync, monitor and marker block
// Assumes: register port is the decoded parallel side of the serial configuration port
// Notes: all addresses are 12-bit byte offsets, all registers 8 bits wide
package sync_marker_pkg;

  // register offsets
  localparam logic [11:0] ADDR_OVR_THRESH = 12'h10a;
  localparam logic [11:0] ADDR_OVR_CFG = 12'h10b;
  localparam logic [11:0] ADDR_OUT_FORMAT = 12'h110;
  localparam logic [11:0] ADDR_OVR_LSB = 12'h116;
  localparam logic [11:0] ADDR_FREQ_RANGE = 12'h132;
  localparam logic [11:0] ADDR_MON_STATUS = 12'h140;
  localparam logic [11:0] ADDR_PIN_CFG = 12'h146;
  localparam logic [11:0] ADDR_SYNC_MASK = 12'h147;
  localparam logic [11:0] ADDR_NCO_STEP = 12'h148;
  localparam logic [11:0] ADDR_TEST_CFG = 12'h149;
  localparam logic [11:0] ADDR_TS_CFG = 12'h162;
  localparam logic [11:0] ADDR_NYQ_ZONE = 12'h16b;
  localparam logic [11:0] ADDR_DECIM = 12'h169;

  // reset values
  localparam logic [7:0] RST_OVR_THRESH = 8'hff;
  localparam logic [7:0] RST_OVR_CFG = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h01;
  localparam logic [7:0] RST_NCO_STEP = 8'h01;

  // field values and positions
  localparam logic [7:0] PIN_CFG_SYNC_IN = 8'h00;
  localparam logic [7:0] PIN_CFG_OVR_OUT = 8'h02;
  localparam logic [7:0] TS_ENABLE_CODE = 8'hc0;
  localparam logic [7:0] TS_ENABLE_MASK = 8'hc0;
  localparam int DET_BIT = 6;
  localparam int OVR_EN_BIT = 0;
  localparam int OVR_LSB_BIT = 0;
  localparam int RAMP_EN_BIT = 0;
  localparam int DDR_BIT = 0;
  localparam int TS_LANE = 2;

  // timing, in sampling clock cycles
  localparam int SAMPLE_LATENCY = 43;
  localparam int MARKER_LATENCY = 8;
  localparam int MARKER_LEAD = SAMPLE_LATENCY - MARKER_LATENCY;
  // monitor window geometry in ps; the tap comparators sit at these instants
  localparam int SAMPLE_OFFSET_PS = 60;
  localparam int WINDOW_START_PS = -60;
  localparam int WINDOW_END_PS = 140;
  localparam int WINDOW_STEP_PS = 40;
  localparam int NUM_TAPS = (WINDOW_END_PS - WINDOW_START_PS) / WINDOW_STEP_PS + 1;

  // which blocks a reference event may reset; a set bit protects the block
  typedef struct packed {
    logic ramp_hold;
    logic nco_hold;
    logic divider_hold;
  } sync_mask_t;

  // monitor status byte as it reads back
  typedef struct packed {
    logic zero;
    logic reference_edge_seen;
    logic reference_monitor_extra_flag;
    logic [4:0] window_flags;
  } mon_status_t;

endpackage

/* File: core/pipe_delay.sv */
// Purpose: fixed-latency register pipeline
// Assumes: one stage per clock, no stall
// Notes: used for the sample path and the marker path
`timescale 1ns/1ps
module pipe_delay #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1
) (
  input wire logic core_clk, // sampling clock
  input wire logic reset_n, // sync reset, active low
  input wire logic [WIDTH-1:0] din, // value entering
  output logic [WIDTH-1:0] dout // value DEPTH cycles later
);

  logic [WIDTH-1:0] stage [DEPTH];

  initial begin
    if (DEPTH < 1 || WIDTH < 1) begin
      $error("pipe_delay needs DEPTH and WIDTH of at least one");
    end
  end

  // plain shift chain; cleared so nothing stale leaks after reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[DEPTH-1];

endmodule // pipe_delay

/* File: core/sysref_sync_monitor.sv */
// Purpose: reference capture, sync resets, window monitor, time-stamp and overrange marking
// Assumes: core_clk is the sampling clock; tap inputs come from the analog comparator chain
// Notes: one clock domain; register port is the decoded serial configuration port
`timescale 1ns/1ps

// Contract
// - frequency range and Nyquist zone tune correction
// - reference event resets ramp pattern in bypass
// - reference event resets divider and oscillator phase, only while decimation is active
// - pin zero is reference input at code 0x00
// - masks choose which blocks an event resets
// - reference sampled at clock edge plus 60ps
// - monitor watches -60ps to +140ps window
// - five window flags by edge placement
// - status refreshed on each reference rising edge
// - edge-seen bit sticky until software clears
// - status byte layout at 0x140
// - time-stamp registers rising pin edge
// - marker replaces lane two bit at 0xC0
// - data latency 43, marker latency 8
// - time-stamp only in parallel SDR/DDR formats
// - overrange detect, configured at 0x10A/0x10B
// - overrange routable to general pin
// - overrange replaces LSB, every stream in decimation
module sysref_sync_monitor #(
  parameter int SAMPLE_WIDTH = 14,
  parameter int NUM_DDC = 4,
  parameter int DDC_WIDTH = 16,
  parameter int DIV_WIDTH = 8,
  parameter int NCO_WIDTH = 16
) (
  input wire logic core_clk, // sampling clock, rising edge
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [11:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_write, // write strobe, one cycle
  output logic [7:0] reg_rdata, // read data, one cycle after address
  input wire logic general_pin_zero_in, // pin level as seen
  output logic general_pin_zero_out, // pin drive value
  output logic general_pin_zero_oe, // high while driving the pin
  input wire logic [sync_marker_pkg::NUM_TAPS-1:0] ref_taps, // window comparator samples
  input wire logic [SAMPLE_WIDTH-1:0] sample_in, // converter sample, two's complement
  input wire logic [NUM_DDC*DDC_WIDTH-1:0] ddc_in, // down-converter streams
  output logic [SAMPLE_WIDTH-1:0] data_out, // bypass output word
  output logic [NUM_DDC*DDC_WIDTH-1:0] ddc_out, // decimated output streams
  output logic [7:0] freq_range, // input frequency range to correction
  output logic [7:0] nyquist_zone, // zone selection to correction
  output logic decim_active, // decimation chain in use
  output logic ddr_mode, // parallel double data rate
  output logic [DIV_WIDTH-1:0] div_phase, // decimation clock divider state
  output logic [NCO_WIDTH-1:0] nco_phase, // oscillator phase accumulator
  output logic sync_event // one-cycle captured reference event
);

  initial begin
    if (SAMPLE_WIDTH < 10 || SAMPLE_WIDTH > DDC_WIDTH || NUM_DDC < 1) begin
      $error("sysref_sync_monitor: unsupported width or stream count");
    end
    if (NCO_WIDTH < 8 || DIV_WIDTH < 1 || DDC_WIDTH < 1) begin
      $error("sysref_sync_monitor: counters too narrow for the step register");
    end
    if (sync_marker_pkg::NUM_TAPS != 6) begin
      $error("sysref_sync_monitor: window needs six taps");
    end
  end

  // configuration registers
  logic [7:0] ovr_thresh;
  logic [7:0] ovr_cfg;
  logic [7:0] out_format;
  logic [7:0] ovr_lsb;
  logic [7:0] pin_cfg;
  logic [7:0] nco_step;
  logic [7:0] test_cfg;
  logic [7:0] ts_cfg;
  logic [7:0] decim_cfg;
  sync_marker_pkg::sync_mask_t sync_mask;
  sync_marker_pkg::mon_status_t mon_status;

  logic sel_sync_in;
  logic ts_enabled;
  logic pin_q;
  logic pin_rise;
  logic [SAMPLE_WIDTH-1:0] ramp;
  logic [SAMPLE_WIDTH-1:0] sample_q;
  logic [SAMPLE_WIDTH-1:0] data_src;
  logic [SAMPLE_WIDTH-2:0] magnitude;
  logic ovr_now;
  logic [SAMPLE_WIDTH:0] delayed_word;
  logic ovr_late;
  logic ovr_ddc;
  logic marker;
  logic [4:0] window_now;
  logic clear_det;
  logic [4:0] window_flags;
  logic reference_monitor_extra_flag;
  logic reference_edge_seen;

  // register writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ovr_thresh <= sync_marker_pkg::RST_OVR_THRESH;
      ovr_cfg <= sync_marker_pkg::RST_OVR_CFG;
      out_format <= sync_marker_pkg::RST_ZERO;
      ovr_lsb <= sync_marker_pkg::RST_ZERO;
      freq_range <= sync_marker_pkg::RST_ZERO;
      nyquist_zone <= sync_marker_pkg::RST_ZERO; // first zone after reset
      pin_cfg <= sync_marker_pkg::RST_PIN_CFG;
      sync_mask <= '0;
      nco_step <= sync_marker_pkg::RST_NCO_STEP;
      test_cfg <= sync_marker_pkg::RST_ZERO;
      ts_cfg <= sync_marker_pkg::RST_ZERO;
      decim_cfg <= sync_marker_pkg::RST_ZERO;
    end else if (reg_write) begin
      case (reg_addr)
        sync_marker_pkg::ADDR_OVR_THRESH: ovr_thresh <= reg_wdata;
        sync_marker_pkg::ADDR_OVR_CFG: ovr_cfg <= reg_wdata;
        sync_marker_pkg::ADDR_OUT_FORMAT: out_format <= reg_wdata;
        sync_marker_pkg::ADDR_OVR_LSB: ovr_lsb <= reg_wdata;
        sync_marker_pkg::ADDR_FREQ_RANGE: freq_range <= reg_wdata;
        sync_marker_pkg::ADDR_NYQ_ZONE: nyquist_zone <= reg_wdata;
        sync_marker_pkg::ADDR_PIN_CFG: pin_cfg <= reg_wdata;
        sync_marker_pkg::ADDR_SYNC_MASK: sync_mask <= reg_wdata[2:0];
        sync_marker_pkg::ADDR_NCO_STEP: nco_step <= reg_wdata;
        sync_marker_pkg::ADDR_TEST_CFG: test_cfg <= reg_wdata;
        sync_marker_pkg::ADDR_TS_CFG: ts_cfg <= reg_wdata;
        sync_marker_pkg::ADDR_DECIM: decim_cfg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // mode decode
  assign decim_active = decim_cfg[3:0] != 4'h0;
  assign ddr_mode = out_format[sync_marker_pkg::DDR_BIT];
  assign sel_sync_in = pin_cfg == sync_marker_pkg::PIN_CFG_SYNC_IN;
  // marker exists only on the parallel bypass output
  assign ts_enabled = ((ts_cfg & sync_marker_pkg::TS_ENABLE_MASK) ==
                       sync_marker_pkg::TS_ENABLE_CODE) && !decim_active;

  // pin capture on the sampling edge; the analog front end supplies the 60ps skew
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= general_pin_zero_in;
    end
  end

  // only a low-to-high change counts; a held level fires once
  assign pin_rise = general_pin_zero_in && !pin_q && sel_sync_in;
  assign sync_event = pin_rise;

  // ramp test pattern, restarted by a reference event unless masked
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ramp <= '0;
    end else if (pin_rise && !sync_mask.ramp_hold) begin
      ramp <= '0;
    end else begin
      ramp <= ramp + 1'b1;
    end
  end

  // decimation clock divider; only meaningful when decimation is active
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_phase <= '0;
    end else if (decim_active && pin_rise && !sync_mask.divider_hold) begin
      div_phase <= '0;
    end else begin
      div_phase <= div_phase + 1'b1;
    end
  end

  // oscillator phase; reset keeps every device on the same phase
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      nco_phase <= '0;
    end else if (decim_active && pin_rise && !sync_mask.nco_hold) begin
      nco_phase <= '0;
    end else begin
      nco_phase <= nco_phase + NCO_WIDTH'(nco_step);
    end
  end

  // window flags: a tap pair that disagrees brackets the reference change
  // one tap pair per flag; an edge outside the window raises none
  // taps sit at -60, -20, +20, +60, +100, +140 ps around the rising edge
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      window_now[i] = ref_taps[i] ^ ref_taps[i+1];
    end
  end

  assign clear_det = reg_write && reg_addr == sync_marker_pkg::ADDR_MON_STATUS &&
                     reg_wdata[sync_marker_pkg::DET_BIT];

  // window and extra flag follow the latest reference rising edge
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      window_flags <= '0;
      reference_monitor_extra_flag <= 1'b0;
    end else if (pin_rise) begin
      window_flags <= window_now;
      reference_monitor_extra_flag <= |window_now;
    end
  end

  // edge-seen stays until written with a one; a new edge beats the clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reference_edge_seen <= 1'b0;
    end else if (pin_rise) begin
      reference_edge_seen <= 1'b1;
    end else if (clear_det) begin
      reference_edge_seen <= 1'b0;
    end
  end

  // status byte as it reads back; the top bit has no storage behind it
  always_comb begin
    mon_status.zero = 1'b0;
    mon_status.reference_edge_seen = reference_edge_seen;
    mon_status.reference_monitor_extra_flag = reference_monitor_extra_flag;
    mon_status.window_flags = window_flags;
  end

  // overrange: magnitude high bits at or above the threshold byte
  assign magnitude = sample_in[SAMPLE_WIDTH-1] ? ~sample_in[SAMPLE_WIDTH-2:0] :
                     sample_in[SAMPLE_WIDTH-2:0];
  assign ovr_now = ovr_cfg[sync_marker_pkg::OVR_EN_BIT] &&
                   magnitude[SAMPLE_WIDTH-2 -: 8] >= ovr_thresh;

  // capture register; ramp replaces the converter word when the test pattern is on
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sample_q <= '0;
    end else begin
      sample_q <= test_cfg[sync_marker_pkg::RAMP_EN_BIT] ? ramp : sample_in;
    end
  end

  // flag comes straight from the input, one cycle ahead of its sample,
  // so it leads the data by a cycle and never lags it
  pipe_delay #(
    .WIDTH(SAMPLE_WIDTH + 1),
    .DEPTH(sync_marker_pkg::SAMPLE_LATENCY - 1)
  ) u_sample_delay (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din({ovr_now, sample_q}),
    .dout(delayed_word)
  );

  // marker path is short on purpose: it is not latency matched
  pipe_delay #(
    .WIDTH(1),
    .DEPTH(sync_marker_pkg::MARKER_LATENCY)
  ) u_marker_delay (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(pin_rise && ts_enabled),
    .dout(marker)
  );

  assign ovr_late = delayed_word[SAMPLE_WIDTH];

  // bypass word with marker and overrange substitution
  always_comb begin
    data_src = delayed_word[SAMPLE_WIDTH-1:0];
    if (ovr_lsb[sync_marker_pkg::OVR_LSB_BIT]) begin
      data_src[0] = ovr_late;
    end
    if (ts_enabled) begin
      data_src[sync_marker_pkg::TS_LANE] = marker;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_out <= '0;
    end else begin
      data_out <= data_src;
    end
  end

  // decimated streams each carry the overrange flag in their LSB
  assign ovr_ddc = ovr_lsb[sync_marker_pkg::OVR_LSB_BIT] && decim_active;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ddc_out <= '0;
    end else begin
      for (int k = 0; k < NUM_DDC; k++) begin
        ddc_out[k*DDC_WIDTH +: DDC_WIDTH] <= ddc_in[k*DDC_WIDTH +: DDC_WIDTH];
        if (ovr_ddc) begin
          ddc_out[k*DDC_WIDTH] <= ovr_late;
        end
      end
    end
  end

  // pin drive: only when configured as overrange output, never as reference input
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      general_pin_zero_out <= 1'b0;
      general_pin_zero_oe <= 1'b0;
    end else begin
      general_pin_zero_out <= ovr_late;
      general_pin_zero_oe <= pin_cfg == sync_marker_pkg::PIN_CFG_OVR_OUT;
    end
  end

  // read mux, registered; unmapped addresses read zero
  // reading the status has no side effect; only a written one clears edge-seen
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        sync_marker_pkg::ADDR_OVR_THRESH: reg_rdata <= ovr_thresh;
        sync_marker_pkg::ADDR_OVR_CFG: reg_rdata <= ovr_cfg;
        sync_marker_pkg::ADDR_OUT_FORMAT: reg_rdata <= out_format;
        sync_marker_pkg::ADDR_OVR_LSB: reg_rdata <= ovr_lsb;
        sync_marker_pkg::ADDR_FREQ_RANGE: reg_rdata <= freq_range;
        sync_marker_pkg::ADDR_MON_STATUS: reg_rdata <= mon_status;
        sync_marker_pkg::ADDR_PIN_CFG: reg_rdata <= pin_cfg;
        sync_marker_pkg::ADDR_SYNC_MASK: reg_rdata <= {5'h00, sync_mask};
        sync_marker_pkg::ADDR_NCO_STEP: reg_rdata <= nco_step;
        sync_marker_pkg::ADDR_TEST_CFG: reg_rdata <= test_cfg;
        sync_marker_pkg::ADDR_TS_CFG: reg_rdata <= ts_cfg;
        sync_marker_pkg::ADDR_NYQ_ZONE: reg_rdata <= nyquist_zone;
        sync_marker_pkg::ADDR_DECIM: reg_rdata <= decim_cfg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // sysref_sync_monitor

/* File: bench/sync_monitor_chk.sv */
// Purpose: port checks for the reference sync, monitor and marker block
// Assumes: register writes are seen on the port; the few that gate checks are shadowed
// Notes: the data latency check waits for the sample pipeline to refill after reset
`timescale 1ns/1ps
module sync_monitor_chk #(
  parameter int SAMPLE_WIDTH = 14,
  parameter int DIV_WIDTH = 8,
  parameter int NCO_WIDTH = 16
) (
  input wire logic core_clk, // sampling clock
  input wire logic reset_n, // sync reset, active low
  input wire logic [11:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_write, // write strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic general_pin_zero_in, // reference pin level
  input wire logic general_pin_zero_oe, // pin drive enable
  input wire logic [SAMPLE_WIDTH-1:0] sample_in, // sample entering
  input wire logic [SAMPLE_WIDTH-1:0] data_out, // bypass word
  input wire logic [7:0] nyquist_zone, // zone register
  input wire logic decim_active, // decimation in use
  input wire logic [DIV_WIDTH-1:0] div_phase, // divider state
  input wire logic [NCO_WIDTH-1:0] nco_phase, // oscillator phase
  input wire logic sync_event // captured event
);
  logic [7:0] pin_cfg;
  logic [7:0] sync_mask;
  logic [7:0] ts_cfg;
  logic ramp_on;
  logic [5:0] fill;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // shadow only the registers that gate the checks below
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_cfg <= 8'h01;
      sync_mask <= 8'h00;
      ts_cfg <= 8'h00;
      ramp_on <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == 12'h149) ramp_on <= reg_wdata[0];
      if (reg_addr == 12'h146) pin_cfg <= reg_wdata;
      if (reg_addr == 12'h147) sync_mask <= reg_wdata;
      if (reg_addr == 12'h162) ts_cfg <= reg_wdata;
    end
  end
  // refill count; until it tops out the pipe still holds reset zeros or ramp words
  always_ff @(posedge core_clk) begin
    if (!reset_n || ramp_on) fill <= 6'h00;
    else if (fill != 6'h2c) fill <= fill + 6'h01;
  end
  property p_gate;
    sync_event |-> pin_cfg == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("event while pin not a reference");
  property p_edge;
    sync_event |-> general_pin_zero_in && !$past(general_pin_zero_in);
  endproperty
  a_edge: assert property (p_edge) else $error("event without a rising pin");
  property p_div_reset;
    sync_event && decim_active && !sync_mask[0] |=> div_phase == '0;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not cleared");
  property p_nco_reset;
    sync_event && decim_active && !sync_mask[1] |=> nco_phase == '0;
  endproperty
  a_nco_reset: assert property (p_nco_reset) else $error("phase not cleared");
  property p_nco_keep;
    sync_event && (sync_mask[1] || !decim_active) |=>
      nco_phase == NCO_WIDTH'($past(nco_phase) + 1);
  endproperty
  a_nco_keep: assert property (p_nco_keep) else $error("protected phase disturbed");
  property p_marker;
    ts_cfg[7:6] == 2'h3 && !decim_active && sync_event
      |-> ##9 data_out[2] ##1 !data_out[2];
  endproperty
  a_marker: assert property (p_marker) else $error("marker misplaced");
  property p_data_lat;
    fill == 6'h2c && !decim_active |->
      data_out[SAMPLE_WIDTH-1:3] == $past(sample_in[SAMPLE_WIDTH-1:3], 44)
      && data_out[1] == $past(sample_in[1], 44);
  endproperty
  a_data_lat: assert property (p_data_lat) else $error("sample latency wrong");
  property p_oe;
    general_pin_zero_oe == ($past(pin_cfg) == 8'h02);
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive does not follow config");
  property p_rdata;
    $past(reg_addr) == 12'h16b |-> reg_rdata == $past(nyquist_zone);
  endproperty
  a_rdata: assert property (p_rdata) else $error("zone readback wrong");
  property p_nyq_reset;
    $rose(reset_n) |-> nyquist_zone == 8'h00;
  endproperty
  a_nyq_reset: assert property (p_nyq_reset) else $error("zone not first after reset");
endmodule // sync_monitor_chk

/* File: bench/ref_source_model.sv */
// Purpose: external reference source driving pin zero and the window taps
// Assumes: one pulse per request, fixed width, taps settle with the pin
// Notes: code 0..4 puts the edge in that flag window, 5 aligns it clear of the window
`timescale 1ns/1ps
module ref_source_model #(
  parameter int HIGH_CYCLES = 4
) (
  input wire logic core_clk, // sampling clock
  input wire logic fire, // request one pulse
  input wire logic [2:0] window, // edge placement code
  output logic ref_pin, // reference level
  output logic [5:0] taps // comparator samples
);
  logic armed;
  int left = 0;
  initial begin
    ref_pin = 1'b0;
    taps = 6'h00;
  end
  always @(posedge core_clk) armed <= fire;
  // edges launch on the falling clock, giving the most capture margin
  always @(negedge core_clk) begin
    if (armed && left == 0) begin
      ref_pin <= 1'b1; // single sync pulse
      taps <= (window > 3'h4) ? 6'h3f : 6'(6'h3f << (window + 3'h1));
      left <= HIGH_CYCLES;
    end else if (left > 1) begin
      left <= left - 1;
    end else if (left == 1) begin
      left <= 0;
      ref_pin <= 1'b0;
      taps <= 6'h00;
    end
  end
endmodule // ref_source_model

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the reference sync, monitor and marker block
// Assumes: the source model drives pin and taps; the bench drives the rest
// Notes: reads queue their expected byte; a monitor compares when data lands
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, fire = 1'b0, fixed = 1'b1;
  logic rd_req = 1'b0, rd_d, pin, pin_out, pin_oe, decim_active, ddr_mode, sync_event;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, freq_range, nyquist_zone, div_phase, r;
  logic [2:0] window = 3'h0;
  logic [5:0] ref_taps;
  logic [13:0] sample_in = 14'h0000, data_out, fixed_val = 14'h0000;
  logic [63:0] ddc_in = 64'h0, ddc_out;
  logic [15:0] nco_phase;
  logic [7:0] exp_q[$];
  logic [11:0] adr_q[$];
  logic [11:0] radr[8] = '{12'h10a, 12'h10b, 12'h146, 12'h148, 12'h16b, 12'h132, 12'h140, 12'h162};
  logic [7:0] rval[8] = '{8'hff, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int errors = 0, num_checks = 0, cycles = 0, hits = 0;
  sysref_sync_monitor sysref_sync_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
    .general_pin_zero_in(pin), .general_pin_zero_out(pin_out), .general_pin_zero_oe(pin_oe),
    .ref_taps(ref_taps), .sample_in(sample_in), .ddc_in(ddc_in), .data_out(data_out),
    .ddc_out(ddc_out), .freq_range(freq_range), .nyquist_zone(nyquist_zone),
    .decim_active(decim_active), .ddr_mode(ddr_mode), .div_phase(div_phase),
    .nco_phase(nco_phase), .sync_event(sync_event));
  ref_source_model ref_source_model_inst (.core_clk(core_clk), .fire(fire), .window(window),
    .ref_pin(pin), .taps(ref_taps));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    exp_q.push_back(e);
    adr_q.push_back(a);
    rd_req = 1'b1;
    @(negedge core_clk);
    rd_req = 1'b0;
  endtask
  task automatic pulse(input logic [2:0] w);
    @(negedge core_clk);
    window = w;
    fire = 1'b1;
    @(negedge core_clk);
    fire = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
  // quiet stretch first so earlier markers and sample bits are flushed
  task automatic marker(input logic [2:0] w, input int n);
    repeat (50) @(negedge core_clk);
    @(posedge core_clk);
    hits = 0;
    pulse(w);
    repeat (12) @(negedge core_clk);
    chk("marker count", 16'(n), 16'(hits));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // stimulus on the falling edge; bit 2 held low so only markers show there
  always @(negedge core_clk) begin
    sample_in <= fixed ? fixed_val : 14'($urandom) & 14'h3ffb;
    ddc_in <= {$urandom, $urandom};
  end
  // read data lands one edge after the address is taken
  always @(posedge core_clk) rd_d <= rd_req;
  always @(negedge core_clk) begin
    if (rd_d) chk($sformatf("reg %h", adr_q.pop_front()), 16'(exp_q.pop_front()), 16'(reg_rdata));
    if (data_out[2] === 1'b1) hits++;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(77));
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    fixed = 1'b0;
    for (int i = 0; i < 8; i++) rd(radr[i], rval[i]);
    r = 8'($urandom);
    wr(12'h132, r);
    wr(12'h16b, 8'h02);
    wr(12'h0ff, 8'h5a); // unmapped, dropped
    rd(12'h132, r);
    rd(12'h16b, 8'h02);
    chk("freq_range", 16'(r), 16'(freq_range));
    chk("nyquist_zone", 16'h0002, 16'(nyquist_zone));
    wr(12'h146, 8'h00);
    for (int k = 0; k < 6; k++) begin
      pulse(3'(k));
      rd(12'h140, (k < 5) ? 8'h60 | (8'h01 << k) : 8'h40);
      wr(12'h140, 8'hff);
      rd(12'h140, (k < 5) ? 8'h20 | (8'h01 << k) : 8'h00);
    end
    wr(12'h146, 8'h01);
    pulse(3'h1);
    rd(12'h140, 8'h00);
    wr(12'h146, 8'h00);
    wr(12'h162, 8'hc0);
    for (int d = 0; d < 2; d++) begin
      wr(12'h110, 8'(d));
      chk("ddr_mode", 16'(d), 16'(ddr_mode));
      marker(3'h1, 1);
    end
    wr(12'h169, 8'h01);
    marker(3'h2, 0);
    for (int m = 0; m < 8; m++) begin
      wr(12'h147, 8'(m));
      pulse(3'(m % 5));
    end
    wr(12'h162, 8'h00);
    wr(12'h169, 8'h00);
    wr(12'h147, 8'h00);
    wr(12'h149, 8'h01);
    pulse(3'h1);
    repeat (44) @(negedge core_clk);
    chk("ramp restart", 16'h0007, 16'(data_out));
    wr(12'h149, 8'h00);
    wr(12'h10a, 8'h10);
    wr(12'h116, 8'h01);
    wr(12'h146, 8'h02);
    for (int v = 0; v < 4; v++) begin
      wr(12'h169, v[1] ? 8'h01 : 8'h00);
      @(posedge core_clk);
      fixed_val = v[0] ? 14'h1ff8 : 14'h0000;
      fixed = 1'b1;
      repeat (60) @(negedge core_clk);
      if (v[1]) chk("ddc lsbs", 16'({4{v[0]}}),
        16'({ddc_out[48], ddc_out[32], ddc_out[16], ddc_out[0]}));
      else chk("ovr lsb", 16'(v[0]), 16'(data_out[0]));
      chk("ovr pin", 16'(v[0]), 16'(pin_out));
      chk("ovr oe", 16'h0001, 16'(pin_oe));
    end
    conclude();
  end
endmodule // tb_top
bind sysref_sync_monitor sync_monitor_chk #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .DIV_WIDTH(DIV_WIDTH),
  .NCO_WIDTH(NCO_WIDTH)) sync_monitor_chk_inst (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .general_pin_zero_in(general_pin_zero_in), .general_pin_zero_oe(general_pin_zero_oe),
  .sample_in(sample_in), .data_out(data_out), .nyquist_zone(nyquist_zone),
  .decim_active(decim_active), .div_phase(div_phase), .nco_phase(nco_phase),
  .sync_event(sync_event));
